// ### flash_seq_params.svh
// Constants of the flash erase and program sequencer.
// What this block does
// - Before erasing, program every byte to 00h using the byte program flow.
// - Write 20h twice to the command register to start an erase.
// - Write 0A0h with the byte address to arm erase verify.
// - After erase verify set-up, read once and compare with 0FFh.
// - Verify upward from 0000h to the last address or first failure.
// - On verify failure keep the address, erase again, resume there.
// - Erase retries are limited to 1000 or 6000 by temperature grade.
// - Program a byte with repeated 10us pulses, verifying after each.
// - At most 25 program operations per byte, then it is a failure.
// - Write 40h, then a write of address and data starts programming.
// - Write 0C0h to arm program verify, then read and compare once.
// - Two writes of 0FFh abort a set-up; follow with a valid command.
`ifndef FLASH_SEQ_PARAMS_SVH
`define FLASH_SEQ_PARAMS_SVH
`define CMD_ERASE       8'h20
`define CMD_ERASE_VFY   8'ha0
`define CMD_PROGRAM     8'h40
`define CMD_PROGRAM_VFY 8'hc0
`define CMD_RESET       8'hff
`define CMD_READ        8'h00
`define DATA_ERASED     8'hff
`define DATA_ZERO       8'h00
`define ADDR_FIRST      17'h00000
`define ADDR_LAST       17'h1ffff
`define CLK_MHZ         250
`define PROG_PULSE_NS   10000
`define PROG_PULSE_CYC  ((`PROG_PULSE_NS * `CLK_MHZ) / 1000)
`define ERASE_PULSE_US  9500
`define ERASE_PULSE_CYC (`ERASE_PULSE_US * `CLK_MHZ)
`define PROG_MAX        5'd25
`define ERASE_MAX_G1    13'd1000
`define ERASE_MAX_G36   13'd6000
`define BUS_CYC         6'd40
`define RECOVER_CYC     6'd63
`endif

// ### flash_seq_pkg.sv
// Types of the flash erase and program sequencer.
package flash_seq_pkg;
  typedef enum logic [4:0] {
    ST_IDLE   = 5'b00000,
    ST_WRITE  = 5'b00001,
    ST_READ   = 5'b00010,
    ST_WAIT   = 5'b00011,
    ST_P_SET  = 5'b00100,
    ST_P_DATA = 5'b00101,
    ST_P_VSET = 5'b00110,
    ST_P_VRD  = 5'b00111,
    ST_E_PRE  = 5'b01000,
    ST_E_SET1 = 5'b01001,
    ST_E_SET2 = 5'b01010,
    ST_E_VSET = 5'b01011,
    ST_E_VRD  = 5'b01100,
    ST_ABORT1 = 5'b01101,
    ST_ABORT2 = 5'b01110,
    ST_TO_RD  = 5'b01111,
    ST_DONE   = 5'b10000
  } state_e;
  typedef struct packed {
    logic        ce_n;
    logic        oe_n;
    logic        we_n;
    logic        dq_oe;
    logic [16:0] addr;
    logic [7:0]  dq;
  } pins_s;
  typedef struct packed {
    state_e      st;
    state_e      ret;
    logic        erase_job;
    logic        pre_pass;
    logic        error;
    logic        done;
    logic [7:0]  rd;
    logic [7:0]  want;
    logic [16:0] addr;
    logic [4:0]  tries;
    logic [12:0] retries;
    logic [5:0]  bus_cnt;
    logic [23:0] wait_cnt;
    pins_s       pins;
  } state_s;
endpackage

// ### flash_seq.sv
// Host sequencer that erases and programs a bulk erase flash over its pins.
`include "flash_seq_params.svh"
module flash_seq
  import flash_seq_pkg::*;
(
  // Clock and reset.
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_SYS_RST,
  // Job request.
  input  wire logic        i_start,
  input  wire logic        i_erase,
  input  wire logic [16:0] i_addr,
  input  wire logic [7:0]  i_data,
  input  wire logic        i_grade1,
  // Job status.
  output logic             o_busy,
  output logic             o_done,
  output logic             o_error,
  output logic [16:0]      o_fail_addr,
  // Flash pins.
  output logic             o_ce_n,
  output logic             o_oe_n,
  output logic             o_we_n,
  output logic [16:0]      o_a,
  output logic [7:0]       o_dq,
  output logic             o_dq_oe,
  input  wire logic [7:0]  i_dq
);
  state_s s;
  state_s next_s;
  logic [7:0] dq_meta;
  logic [7:0] dq_sync;
  logic [12:0] erase_max;

  // Read data pins pass two flip-flops.
  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      dq_meta <= 8'h00;
      dq_sync <= 8'h00;
    end
    else
    begin
      dq_meta <= i_dq;
      dq_sync <= dq_meta;
    end
  end

  assign erase_max = i_grade1 ? `ERASE_MAX_G1 : `ERASE_MAX_G36;

  // Starts one bus write cycle and returns to the given state.
  function automatic state_s bus_write(state_s c, logic [7:0] d,
                                       logic [16:0] a, state_e r);
    state_s n;
    n = c;
    n.pins.ce_n  = 1'b0;
    n.pins.we_n  = 1'b0;
    n.pins.oe_n  = 1'b1;
    n.pins.dq_oe = 1'b1;
    n.pins.dq    = d;
    n.pins.addr  = a;
    n.bus_cnt    = `BUS_CYC;
    n.ret        = r;
    n.st         = ST_WRITE;
    return n;
  endfunction

  always_comb
  begin
    next_s = s;
    next_s.done = 1'b0;
    case (s.st)
      ST_IDLE:
      begin
        if (i_start)
        begin
          next_s.error     = 1'b0;
          next_s.erase_job = i_erase;
          next_s.tries     = 5'd0;
          next_s.retries   = 13'd0;
          if (i_erase)
          begin
            next_s.pre_pass = 1'b1;
            next_s.addr     = `ADDR_FIRST;
            next_s.want     = `DATA_ZERO;
            next_s.st       = ST_P_SET;
          end
          else
          begin
            next_s.pre_pass = 1'b0;
            next_s.addr     = i_addr;
            next_s.want     = i_data;
            next_s.st       = ST_P_SET;
          end
        end
      end
      ST_WRITE:
      begin
        next_s.bus_cnt = s.bus_cnt - 6'd1;
        if (s.bus_cnt == (`BUS_CYC >> 1))
        begin
          next_s.pins.we_n = 1'b1;
        end
        if (s.bus_cnt == 6'd0)
        begin
          next_s.pins.ce_n  = 1'b1;
          next_s.pins.dq_oe = 1'b0;
          next_s.st         = (s.wait_cnt != 24'd0) ? ST_WAIT : s.ret;
        end
      end
      ST_READ:
      begin
        next_s.bus_cnt = s.bus_cnt - 6'd1;
        if (s.bus_cnt == 6'd0)
        begin
          next_s.rd        = dq_sync;
          next_s.pins.ce_n = 1'b1;
          next_s.pins.oe_n = 1'b1;
          next_s.ret       = ST_READ;
          next_s.st        = s.ret;
        end
      end
      ST_WAIT:
      begin
        next_s.wait_cnt = s.wait_cnt - 24'd1;
        if (s.wait_cnt == 24'd1)
        begin
          next_s.st = s.ret;
        end
      end
      ST_P_SET:
      begin
        next_s = bus_write(s, `CMD_PROGRAM, s.addr, ST_P_DATA);
      end
      ST_P_DATA:
      begin
        next_s = bus_write(s, s.want, s.addr, ST_P_VSET);
        next_s.tries    = s.tries + 5'd1;
        next_s.wait_cnt = 24'(`PROG_PULSE_CYC);
      end
      ST_P_VSET:
      begin
        next_s = bus_write(s, `CMD_PROGRAM_VFY, s.addr, ST_P_VRD);
        next_s.wait_cnt = {18'd0, `RECOVER_CYC};
      end
      ST_P_VRD:
      begin
        if (s.ret != ST_READ)
        begin
          next_s.pins.ce_n = 1'b0;
          next_s.pins.oe_n = 1'b0;
          next_s.bus_cnt   = `BUS_CYC;
          next_s.ret       = ST_P_VRD;
          next_s.st        = ST_READ;
        end
        else if (s.rd == s.want)
        begin
          next_s.tries = 5'd0;
          if (s.pre_pass && s.addr != `ADDR_LAST)
          begin
            next_s.addr = s.addr + 17'd1;
            next_s.st   = ST_P_SET;
          end
          else if (s.pre_pass)
          begin
            next_s.pre_pass = 1'b0;
            next_s.addr     = `ADDR_FIRST;
            next_s.st       = ST_E_SET1;
          end
          else
          begin
            next_s.st = ST_TO_RD;
          end
        end
        else if (s.tries >= `PROG_MAX)
        begin
          next_s.error = 1'b1;
          next_s.st    = ST_ABORT1;
        end
        else
        begin
          next_s.st = ST_P_SET;
        end
      end
      ST_E_SET1:
      begin
        next_s = bus_write(s, `CMD_ERASE, s.addr, ST_E_SET2);
        next_s.retries = s.retries + 13'd1;
      end
      ST_E_SET2:
      begin
        next_s = bus_write(s, `CMD_ERASE, s.addr, ST_E_VSET);
        next_s.wait_cnt = 24'(`ERASE_PULSE_CYC);
      end
      ST_E_VSET:
      begin
        next_s = bus_write(s, `CMD_ERASE_VFY, s.addr, ST_E_VRD);
        next_s.wait_cnt = {18'd0, `RECOVER_CYC};
      end
      ST_E_VRD:
      begin
        if (s.ret != ST_READ)
        begin
          next_s.pins.ce_n = 1'b0;
          next_s.pins.oe_n = 1'b0;
          next_s.bus_cnt   = `BUS_CYC;
          next_s.ret       = ST_E_VRD;
          next_s.st        = ST_READ;
        end
        else if (s.rd == `DATA_ERASED)
        begin
          if (s.addr == `ADDR_LAST)
          begin
            next_s.st = ST_TO_RD;
          end
          else
          begin
            next_s.addr = s.addr + 17'd1;
            next_s.ret  = ST_E_VSET;
            next_s.st   = ST_E_VSET;
          end
        end
        else if (s.retries >= erase_max)
        begin
          next_s.error = 1'b1;
          next_s.st    = ST_ABORT1;
        end
        else
        begin
          next_s.st = ST_E_SET1;
        end
      end
      ST_ABORT1:
      begin
        next_s = bus_write(s, `CMD_RESET, s.addr, ST_ABORT2);
      end
      ST_ABORT2:
      begin
        next_s = bus_write(s, `CMD_RESET, s.addr, ST_TO_RD);
      end
      ST_TO_RD:
      begin
        next_s = bus_write(s, `CMD_READ, s.addr, ST_DONE);
      end
      ST_DONE:
      begin
        next_s.done = 1'b1;
        next_s.st   = ST_IDLE;
      end
      default:
      begin
        next_s.st = ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge I_CLK_SYS or posedge I_SYS_RST)
  begin
    if (I_SYS_RST)
    begin
      s <= '{st: ST_IDLE, ret: ST_IDLE,
             pins: '{ce_n: 1'b1, oe_n: 1'b1, we_n: 1'b1,
                     dq_oe: 1'b0, addr: 17'h00000, dq: 8'h00},
             default: '0};
    end
    else
    begin
      s <= next_s;
    end
  end

  assign o_busy      = (s.st != ST_IDLE);
  assign o_done      = s.done;
  assign o_error     = s.error;
  assign o_fail_addr = s.addr;
  assign o_ce_n      = s.pins.ce_n;
  assign o_oe_n      = s.pins.oe_n;
  assign o_we_n      = s.pins.we_n;
  assign o_a         = s.pins.addr;
  assign o_dq        = s.pins.dq;
  assign o_dq_oe     = s.pins.dq_oe;
endmodule

// ### flash_seq_chk.sv
// Assertion checker for the flash sequencer pins and status.
module flash_seq_chk (
  // Clock, reset and job.
  input  wire logic        I_CLK_SYS,
  input  wire logic        I_SYS_RST,
  input  wire logic        i_start,
  // Status and pins.
  input  wire logic        o_busy,
  input  wire logic        o_done,
  input  wire logic        o_error,
  input  wire logic        o_ce_n,
  input  wire logic        o_oe_n,
  input  wire logic        o_we_n,
  input  wire logic [16:0] o_a,
  input  wire logic [7:0]  o_dq,
  input  wire logic        o_dq_oe
);
  default clocking cb @(posedge I_CLK_SYS);
  endclocking
  default disable iff (I_SYS_RST);
  sequence wr_low;
    (!o_we_n && $stable(o_a) && $stable(o_dq))[*8];
  endsequence
  sequence rd_low;
    (!o_oe_n && $stable(o_a))[*8];
  endsequence
  chk_no_clash: assert property (!(!o_we_n && !o_oe_n))
    else $error("write and read strobes low together");
  chk_we_in_ce: assert property (!o_we_n |-> !o_ce_n)
    else $error("write strobe without chip select");
  chk_dq_drive: assert property (!o_we_n |-> o_dq_oe)
    else $error("write without data drive");
  chk_rd_float: assert property (!o_oe_n |-> !o_dq_oe)
    else $error("data driven during read");
  chk_wr_shape: assert property ($fell(o_we_n) |=> wr_low ##13 $rose(o_we_n))
    else $error("write pulse shape wrong");
  chk_rd_shape: assert property ($fell(o_oe_n) |=> rd_low)
    else $error("read cycle too short or address moved");
  chk_done_one: assert property (o_done |=> !o_done)
    else $error("done longer than one cycle");
  chk_start_busy: assert property (i_start && !o_busy |=> o_busy)
    else $error("start not taken");
  chk_err_clear: assert property (i_start && !o_busy |=> !o_error)
    else $error("error not cleared by start");
  chk_err_hold: assert property (!o_busy && !i_start |=> $stable(o_error))
    else $error("error changed while idle");
endmodule
bind flash_seq flash_seq_chk flash_seq_chk_inst (.I_CLK_SYS(I_CLK_SYS),
  .I_SYS_RST(I_SYS_RST), .i_start(i_start), .o_busy(o_busy),
  .o_done(o_done), .o_error(o_error), .o_ce_n(o_ce_n), .o_oe_n(o_oe_n),
  .o_we_n(o_we_n), .o_a(o_a), .o_dq(o_dq), .o_dq_oe(o_dq_oe));

// ### flash_dev.sv
// Behavioural model of the flash device command register and one byte.
module flash_dev (
  input  wire logic        ce_n,
  input  wire logic        oe_n,
  input  wire logic        we_n,
  input  wire logic [16:0] a,
  input  wire logic [7:0]  din,
  output logic [7:0]       dout
);
  timeunit 1ns;
  timeprecision 1ps;
  int          need = 1;
  int          pulses = 0;
  int          aborts = 0;
  logic [7:0]  cmd = 8'h00;
  logic [7:0]  pdata = 8'h00;
  logic [16:0] paddr = 17'h00000;
  logic [7:0]  last = 8'h00;
  logic [7:0]  val;
  logic        parm = 1'b0;
  always @(posedge we_n)
    if (!ce_n)
    begin
      if (parm)
      begin
        paddr = a;
        pdata = din;
        pulses++;
        parm = 1'b0;
      end
      else
      begin
        if (din == 8'hff && cmd == 8'hff)
          aborts++;
        parm = (din == 8'h40);
        cmd = din;
      end
    end
  always_comb
    if (cmd == 8'hc0)
      val = (pulses >= need) ? pdata : ~pdata;
    else
      val = 8'hff;
  always @(posedge oe_n)
    last = val;
  assign dout = (!ce_n && !oe_n) ? val : ~last;
endmodule

// ### test_flash_erase_program_algorithm.sv
// Self-checking testbench for the flash sequencer.
module test_flash_erase_program_algorithm;
  timeunit 1ns;
  timeprecision 1ps;
  logic        I_CLK_SYS = 1'b0;
  logic        I_SYS_RST = 1'b1;
  logic        start = 1'b0;
  logic        erase = 1'b0;
  logic [16:0] addr = 17'h00000;
  logic [7:0]  data = 8'h00;
  logic        busy, done, error, ce_n, oe_n, we_n, dq_oe;
  logic [16:0] fail_addr, a;
  logic [7:0]  dq, dq_in;
  int          err_total = 0;
  int          checks = 0;
  flash_seq flash_seq_inst (.I_CLK_SYS(I_CLK_SYS), .I_SYS_RST(I_SYS_RST),
    .i_start(start), .i_erase(erase), .i_addr(addr), .i_data(data),
    .i_grade1(1'b1), .o_busy(busy), .o_done(done), .o_error(error),
    .o_fail_addr(fail_addr), .o_ce_n(ce_n), .o_oe_n(oe_n), .o_we_n(we_n),
    .o_a(a), .o_dq(dq), .o_dq_oe(dq_oe), .i_dq(dq_in));
  flash_dev flash_dev_inst (.ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .a(a),
    .din(dq), .dout(dq_in));
  always #2 I_CLK_SYS = ~I_CLK_SYS;
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks++;
    if (seen !== exp)
    begin
      err_total++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic stop_test();
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic idle_pins();
    check({ce_n, oe_n, we_n, dq_oe, busy, done, error, a, dq}, 32'he0000000);
  endtask
  task automatic wait_pulses(input int k);
    int n;
    n = 0;
    while (flash_dev_inst.pulses < k && n < 5000)
    begin
      @(posedge I_CLK_SYS);
      #1;
      n++;
    end
  endtask
  task automatic run_job(input logic [16:0] ad, input logic [7:0] d,
                         input logic poke);
    int n;
    @(posedge I_CLK_SYS);
    addr <= ad;
    data <= d;
    start <= 1'b1;
    n = 0;
    while (n == 0 || (done !== 1'b1 && n < 80000))
    begin
      @(posedge I_CLK_SYS);
      start <= poke && n == 100;
      addr <= poke ? ad ^ 17'h00001 : ad;
      #1;
      n++;
    end
    check(done, 1'b1);
  endtask
  task automatic t_reset();
    repeat (2) @(posedge I_CLK_SYS);
    #1;
    idle_pins();
    @(posedge I_CLK_SYS);
    I_SYS_RST <= 1'b0;
    $display("reset test done");
  endtask
  task automatic t_erase();
    @(posedge I_CLK_SYS);
    erase <= 1'b1;
    addr <= 17'h00005;
    data <= 8'h5a;
    start <= 1'b1;
    @(posedge I_CLK_SYS);
    start <= 1'b0;
    wait_pulses(1);
    check({flash_dev_inst.paddr, flash_dev_inst.pdata}, 25'h0000000);
    wait_pulses(2);
    check(flash_dev_inst.paddr, 17'h00001);
    @(posedge I_CLK_SYS);
    I_SYS_RST <= 1'b1;
    erase <= 1'b0;
    @(posedge I_CLK_SYS);
    #1;
    idle_pins();
    @(posedge I_CLK_SYS);
    I_SYS_RST <= 1'b0;
    $display("erase start test done");
  endtask
  task automatic t_prog(input int need_n, input logic [16:0] ad,
                        input logic [7:0] d, input logic poke);
    flash_dev_inst.need = need_n;
    flash_dev_inst.pulses = 0;
    flash_dev_inst.aborts = 0;
    run_job(ad, d, poke);
    check({flash_dev_inst.paddr, flash_dev_inst.pdata}, {ad, d});
    check(flash_dev_inst.pulses, need_n > 25 ? 25 : need_n);
    check(error, need_n > 25);
    if (need_n > 25)
    begin
      check(flash_dev_inst.aborts, 1);
      check(flash_dev_inst.cmd, 8'h00);
      check(fail_addr, ad);
    end
    $display("program test need %0d done", need_n);
  endtask
  initial
  begin
    #400000;
    err_total++;
    stop_test();
  end
  initial
  begin
    t_reset();
    t_erase();
    t_prog(1, 17'h1ffff, 8'ha5, 1'b0);
    t_prog(3, 17'h00123, 8'h3c, 1'b1);
    t_prog(26, 17'h0aaaa, 8'h81, 1'b0);
    stop_test();
  end
endmodule
